// ---- hdl/gsp_consts.vh ----
// constants for the special-function I/O port: offsets, fields, resets
// Operation
// - dma_signal_config register configures DMA request/acknowledge pin functions.
// - optional 3-tap input filter per configured special-function signal.
// - per-signal polarity bit; software must match attached signal.
// - each external interrupt selects level, rising or falling detection.
// - edge mode sets pending bit on chosen edge until software clears.
// - writing one to a pending bit clears it; zero leaves it.
// - level mode passes conditioned level straight to controller, no latch.
// - two data registers cover pins 0-31 and 32-63, one bit each.
// - drive bit one selects open-drain, zero selects push-pull output.
// - six external interrupt lines numbered 0 to 5 go out.
// - mux bit zero selects peripheral signal, one selects GPIO; resets zero.
`ifndef GSP_CONSTS_VH
`define GSP_CONSTS_VH
`define GSP_ADDR_W 32
`define GSP_OFF_DMA_CFG 32'hf003_0010
`define GSP_OFF_EXT_CFG 32'hf003_0014
`define GSP_OFF_EXT_PND 32'hf003_0018
`define GSP_OFF_DATA_LO 32'hf003_001c
`define GSP_OFF_DATA_HI 32'hf003_0020
`define GSP_OFF_DRV_LO 32'hf003_0024
`define GSP_OFF_DRV_HI 32'hf003_0028
`define GSP_OFF_MUX 32'hf003_002c
`define GSP_RST_ZERO 32'h0000_0000
// dma_signal_config: per dma signal i (0..7) a nibble at 4*i
// ext_interrupt_config: per line i (0..5) a nibble at 4*i, active low at bit 24+i
`define GSP_FLD_W 4
`define GSP_FLD_EN 0
`define GSP_FLD_FILT 1
`define GSP_FLD_POL 2
`define GSP_FLD_MODE 2
`define GSP_EXT_POL_BASE 24
`define GSP_MODE_LEVEL 2'b00
`define GSP_MODE_RISE 2'b01
`define GSP_MODE_FALL 2'b10
`define GSP_FILT_TAPS 3
`endif

// ---- hdl/gsp_cond.v ----
// one conditioned special-function input: optional 3-tap filter then polarity
module gsp_cond (
    // clock and reset
    input wire clk,
    input wire reset,
    // control
    input wire filt_en,
    input wire active_low,
    // pin side
    input wire pin_in,
    // conditioned level, active high
    output reg cond_ff
);
`include "gsp_consts.vh"
    reg [`GSP_FILT_TAPS-1:0] tap_ff;
    reg filt_ff;
    reg nxt_filt;
    always @* begin
        nxt_filt = filt_ff;
        if (&tap_ff)
            nxt_filt = 1'b1;
        else if (~|tap_ff)
            nxt_filt = 1'b0;
    end
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            tap_ff <= {`GSP_FILT_TAPS{1'b0}};
            filt_ff <= 1'b0;
            cond_ff <= 1'b0;
        end else begin
            tap_ff <= {tap_ff[`GSP_FILT_TAPS-2:0], pin_in};
            filt_ff <= nxt_filt;
            cond_ff <= (filt_en ? nxt_filt : tap_ff[0]) ^ active_low;
        end
    end
endmodule // gsp_cond

// ---- hdl/gsp_port.v ----
// special-function gpio port: register file, pin drive, dma and interrupt inputs
module gsp_port #(
    parameter NUM_DMA = 8,
    parameter NUM_EXT = 6
) (
    // clock and reset
    input wire clk,
    input wire reset,
    // register port
    input wire [31:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    output reg [31:0] rdata_ff,
    // pins
    input wire [63:0] pin_in,
    output reg [63:0] pin_out_ff,
    output reg [63:0] pin_oe_ff,
    // peripheral side of shared pins
    input wire [63:0] periph_out,
    input wire [63:0] periph_oe,
    output reg [63:0] periph_in_ff,
    // dma request/acknowledge pins, as indices into pin_in
    output reg [NUM_DMA-1:0] dma_req_ff,
    // interrupt controller
    output reg [NUM_EXT-1:0] ext_irq_ff
);
`include "gsp_consts.vh"
    localparam [5:0] DMA_PIN_BASE = 6'd14;
    localparam [5:0] EXT_PIN_BASE = 6'd8;

    reg [31:0] dma_cfg_ff;
    reg [31:0] ext_cfg_ff;
    reg [NUM_EXT-1:0] pend_ff;
    reg [31:0] data_lo_ff;
    reg [31:0] data_hi_ff;
    reg [31:0] drv_lo_ff;
    reg [31:0] drv_hi_ff;
    reg [31:0] mux_ff;
    reg [NUM_EXT-1:0] ext_prev_ff;
    reg [NUM_EXT-1:0] nxt_pend;
    reg [NUM_EXT-1:0] nxt_irq;
    reg [31:0] nxt_rdata;
    reg [63:0] nxt_out;
    reg [63:0] nxt_oe;
    wire [NUM_DMA-1:0] dma_cond;
    wire [NUM_EXT-1:0] ext_cond;
    wire [63:0] data_all;
    wire [63:0] drv_all;
    wire [63:0] gpio_sel;
    reg [NUM_EXT-1:0] clr_mask;
    reg [NUM_DMA-1:0] nxt_dma;
    wire [NUM_EXT-1:0] rise_evt;
    wire [NUM_EXT-1:0] fall_evt;
    integer i_irq;
    integer i_pin;
    integer i_dma;

    // a write strobe aimed at one register offset
    function wr_hit;
        input wr_en;
        input [31:0] a;
        input [31:0] off;
        begin
            wr_hit = wr_en && (a == off);
        end
    endfunction

    function [1:0] ext_mode;
        input [31:0] cfg;
        input integer idx;
        begin
            ext_mode = cfg[idx*`GSP_FLD_W+`GSP_FLD_MODE +: 2];
        end
    endfunction

    function fld_bit;
        input [31:0] cfg;
        input integer idx;
        input integer pos;
        begin
            fld_bit = cfg[idx*`GSP_FLD_W+pos];
        end
    endfunction

    assign data_all = {data_hi_ff, data_lo_ff};
    assign drv_all = {drv_hi_ff, drv_lo_ff};
    // edges of the conditioned level against the last cycle
    assign rise_evt = ext_cond & ~ext_prev_ff;
    assign fall_evt = ~ext_cond & ext_prev_ff;
    // low 32 pins always gpio here, high 32 follow the mux bits
    assign gpio_sel = {mux_ff, 32'hffff_ffff};

    genvar g;
    generate
        for (g = 0; g < NUM_DMA; g = g + 1) begin : g_dma
            wire filt_on;
            wire pol_low;
            assign filt_on = dma_cfg_ff[g*`GSP_FLD_W+`GSP_FLD_FILT];
            assign pol_low = dma_cfg_ff[g*`GSP_FLD_W+`GSP_FLD_POL];
            gsp_cond u_cond (
                .clk(clk),
                .reset(reset),
                .filt_en(filt_on),
                .active_low(pol_low),
                .pin_in(pin_in[DMA_PIN_BASE+g]),
                .cond_ff(dma_cond[g])
            );
        end
        for (g = 0; g < NUM_EXT; g = g + 1) begin : g_ext
            wire filt_on;
            wire pol_low;
            // polarity kept apart from the mode bits
            assign filt_on = ext_cfg_ff[g*`GSP_FLD_W+`GSP_FLD_FILT];
            assign pol_low = ext_cfg_ff[`GSP_EXT_POL_BASE+g];
            gsp_cond u_cond (
                .clk(clk),
                .reset(reset),
                .filt_en(filt_on),
                .active_low(pol_low),
                .pin_in(pin_in[EXT_PIN_BASE+g]),
                .cond_ff(ext_cond[g])
            );
        end
    endgenerate

    always @* begin
        clr_mask = {NUM_EXT{1'b0}};
        if (wr_hit(wr, addr, `GSP_OFF_EXT_PND))
            clr_mask = wdata[NUM_EXT-1:0];
    end

    // interrupt detection
    always @* begin
        nxt_pend = pend_ff & ~clr_mask;
        nxt_irq = {NUM_EXT{1'b0}};
        for (i_irq = 0; i_irq < NUM_EXT; i_irq = i_irq + 1) begin
            case (ext_mode(ext_cfg_ff, i_irq))
                `GSP_MODE_RISE: begin
                    // edge sets pending, set beats clear
                    if (rise_evt[i_irq])
                        nxt_pend[i_irq] = 1'b1;
                end
                `GSP_MODE_FALL: begin
                    if (fall_evt[i_irq])
                        nxt_pend[i_irq] = 1'b1;
                end
                default: begin
                    nxt_pend[i_irq] = 1'b0;
                end
            endcase
            if (!fld_bit(ext_cfg_ff, i_irq, `GSP_FLD_EN))
                nxt_irq[i_irq] = 1'b0;
            else if (ext_mode(ext_cfg_ff, i_irq) == `GSP_MODE_LEVEL)
                nxt_irq[i_irq] = ext_cond[i_irq];
            else
                nxt_irq[i_irq] = nxt_pend[i_irq];
        end
    end

    // pin drive
    always @* begin
        nxt_out = 64'h0000_0000_0000_0000;
        nxt_oe = 64'h0000_0000_0000_0000;
        for (i_pin = 0; i_pin < 64; i_pin = i_pin + 1) begin
            if (gpio_sel[i_pin]) begin
                if (drv_all[i_pin]) begin
                    nxt_out[i_pin] = 1'b0;
                    nxt_oe[i_pin] = ~data_all[i_pin];
                end else begin
                    nxt_out[i_pin] = data_all[i_pin];
                    nxt_oe[i_pin] = 1'b1;
                end
            end else begin
                nxt_out[i_pin] = periph_out[i_pin];
                nxt_oe[i_pin] = periph_oe[i_pin];
            end
        end
    end

    // register read decode
    always @* begin
        nxt_rdata = `GSP_RST_ZERO;
        if (!rd)
            nxt_rdata = `GSP_RST_ZERO;
        else if (addr == `GSP_OFF_DMA_CFG)
            nxt_rdata = dma_cfg_ff;
        else if (addr == `GSP_OFF_EXT_CFG)
            nxt_rdata = ext_cfg_ff;
        else if (addr == `GSP_OFF_EXT_PND)
            nxt_rdata = {{(32-NUM_EXT){1'b0}}, pend_ff};
        else if (addr == `GSP_OFF_DATA_LO)
            nxt_rdata = pin_in[31:0];
        else if (addr == `GSP_OFF_DATA_HI)
            nxt_rdata = pin_in[63:32];
        else if (addr == `GSP_OFF_DRV_LO)
            nxt_rdata = drv_lo_ff;
        else if (addr == `GSP_OFF_DRV_HI)
            nxt_rdata = drv_hi_ff;
        else if (addr == `GSP_OFF_MUX)
            nxt_rdata = mux_ff;
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            dma_cfg_ff <= `GSP_RST_ZERO;
        end else if (wr_hit(wr, addr, `GSP_OFF_DMA_CFG)) begin
            dma_cfg_ff <= wdata;
        end
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            ext_cfg_ff <= `GSP_RST_ZERO;
        end else if (wr_hit(wr, addr, `GSP_OFF_EXT_CFG)) begin
            ext_cfg_ff <= wdata;
        end
    end

    // writes set driven values; no documented reset, cleared for a known start
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            data_lo_ff <= `GSP_RST_ZERO;
        end else if (wr_hit(wr, addr, `GSP_OFF_DATA_LO)) begin
            data_lo_ff <= wdata;
        end
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            data_hi_ff <= `GSP_RST_ZERO;
        end else if (wr_hit(wr, addr, `GSP_OFF_DATA_HI)) begin
            data_hi_ff <= wdata;
        end
    end

    // drive kind, pins 0 to 31
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            drv_lo_ff <= `GSP_RST_ZERO;
        end else if (wr_hit(wr, addr, `GSP_OFF_DRV_LO)) begin
            drv_lo_ff <= wdata;
        end
    end

    // drive kind, pins 32 to 63
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            drv_hi_ff <= `GSP_RST_ZERO;
        end else if (wr_hit(wr, addr, `GSP_OFF_DRV_HI)) begin
            drv_hi_ff <= wdata;
        end
    end

    // pins 32 to 63 start on their peripheral; pins 0 to 31 are always gpio
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            mux_ff <= `GSP_RST_ZERO;
        end else if (wr_hit(wr, addr, `GSP_OFF_MUX)) begin
            mux_ff <= wdata;
        end
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            pend_ff <= {NUM_EXT{1'b0}};
        end else begin
            pend_ff <= nxt_pend;
        end
    end

    // edge history; a polarity change can look like an edge, so clear pending after it
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            ext_prev_ff <= {NUM_EXT{1'b0}};
        end else begin
            ext_prev_ff <= ext_cond;
        end
    end

    // read data stand one cycle, zero otherwise
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_ff <= `GSP_RST_ZERO;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // registered pin drive
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_out_ff <= 64'h0000_0000_0000_0000;
            pin_oe_ff <= 64'h0000_0000_0000_0000;
        end else begin
            pin_out_ff <= nxt_out;
            pin_oe_ff <= nxt_oe;
        end
    end

    // peripherals see the pins one cycle late
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            periph_in_ff <= 64'h0000_0000_0000_0000;
        end else begin
            periph_in_ff <= pin_in;
        end
    end

    // request only when the signal is enabled
    always @* begin
        nxt_dma = {NUM_DMA{1'b0}};
        for (i_dma = 0; i_dma < NUM_DMA; i_dma = i_dma + 1)
            nxt_dma[i_dma] = dma_cond[i_dma] & fld_bit(dma_cfg_ff, i_dma, `GSP_FLD_EN);
    end

    // dma requests out
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            dma_req_ff <= {NUM_DMA{1'b0}};
        end else begin
            dma_req_ff <= nxt_dma;
        end
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            ext_irq_ff <= {NUM_EXT{1'b0}};
        end else begin
            ext_irq_ff <= nxt_irq;
        end
    end
endmodule // gsp_port

// ---- sim/gsp_ext_dev.sv ----
// far-side device model: drives the interrupt and dma pins 8..21
module gsp_ext_dev (
    // clock
    input logic clk,
    // levels asked for by the bench, and a one-cycle lag
    input logic [13:0] lvl,
    input logic slow,
    // pins 8..21
    output logic [13:0] pins_ff
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [13:0] lag_ff;
    always @(posedge clk) begin
        lag_ff <= lvl;
        pins_ff <= slow ? lag_ff : lvl;
    end
endmodule // gsp_ext_dev

// ---- sim/gsp_port_assertions.sv ----
// concurrent checks on the register port and pin outputs
`include "gsp_consts.vh"
module gsp_port_assertions (
    // clock and reset
    input wire clk,
    input wire reset,
    // register port
    input wire [31:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    input wire [31:0] rdata_ff,
    // pins
    input wire [63:0] pin_in,
    input wire [63:0] pin_out_ff,
    input wire [63:0] pin_oe_ff,
    input wire [63:0] periph_in_ff
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_cfg_wr;
        wr && (addr == `GSP_OFF_DMA_CFG || addr == `GSP_OFF_DRV_LO || addr == `GSP_OFF_DRV_HI);
    endsequence
    sequence s_data_wr;
        wr && addr == `GSP_OFF_DATA_LO;
    endsequence
    property p_rd_idle;
        !$past(rd) |-> rdata_ff == `GSP_RST_ZERO;
    endproperty
    property p_pnd_width;
        rd && addr == `GSP_OFF_EXT_PND |=> rdata_ff[31:6] == 26'h000_0000;
    endproperty
    property p_od_low;
        (pin_out_ff[31:0] & ~pin_oe_ff[31:0]) == `GSP_RST_ZERO;
    endproperty
    property p_periph_in;
        !$past(reset) |-> periph_in_ff == $past(pin_in);
    endproperty
    property p_cfg_back;
        logic [31:0] v, a;
        (s_cfg_wr, v = wdata, a = addr) ##1 !wr ##1 (rd && addr == a) |=> rdata_ff == v;
    endproperty
    property p_data_lo;
        rd && addr == `GSP_OFF_DATA_LO |=> rdata_ff == $past(pin_in[31:0]);
    endproperty
    property p_data_hi;
        rd && addr == `GSP_OFF_DATA_HI |=> rdata_ff == $past(pin_in[63:32]);
    endproperty
    // the pad level seen with a pull-up equals the data bit in both drive kinds
    property p_pin_level;
        s_data_wr ##1 !wr |=> (pin_out_ff[31:0] | ~pin_oe_ff[31:0]) == $past(wdata, 2);
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    a_pnd_width: assert property (p_pnd_width) else $error("pending high bits set");
    a_od_low: assert property (p_od_low) else $error("driven high while released");
    a_periph_in: assert property (p_periph_in) else $error("peripheral input lag");
    a_cfg_back: assert property (p_cfg_back) else $error("config readback wrong");
    a_data_lo: assert property (p_data_lo) else $error("low data read wrong");
    a_data_hi: assert property (p_data_hi) else $error("high data read wrong");
    a_pin_level: assert property (p_pin_level) else $error("pad level wrong");
endmodule // gsp_port_assertions
bind gsp_port gsp_port_assertions gsp_port_assertions_i (.clk(clk), .reset(reset),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_ff(rdata_ff), .pin_in(pin_in),
    .pin_out_ff(pin_out_ff), .pin_oe_ff(pin_oe_ff), .periph_in_ff(periph_in_ff));

// ---- sim/gsp_port_tb.sv ----
// self-checking bench for the special-function port
`include "gsp_consts.vh"
module gsp_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, reset = 1, wr = 0, rd = 0, rd_d = 0, slow = 0;
    logic [31:0] addr = '0, wdata = '0, exp_w, v, d, rdata_ff;
    logic [63:0] gp_in = '0, periph_out, periph_oe, pin_out_ff, pin_oe_ff;
    logic [13:0] lvl = '0, dev_pins;
    logic [7:0] dma_req_ff;
    logic [5:0] ext_irq_ff;
    wire [63:0] pin_in = {gp_in[63:22], dev_pins, gp_in[7:0]};
    wire [13:0] sig = {dma_req_ff, ext_irq_ff};
    logic [31:0] exp_q[$];
    logic [31:0] regs[7] = '{`GSP_OFF_DMA_CFG, `GSP_OFF_DRV_LO, `GSP_OFF_DRV_HI,
        `GSP_OFF_MUX, `GSP_OFF_EXT_CFG, `GSP_OFF_EXT_PND, 32'hf003_0030};
    int num_errors = 0, total_checks = 0, seed = 32'h15da, k, n;
    always #25 clk = ~clk;
    gsp_port gsp_port_i (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata_ff(rdata_ff), .pin_in(pin_in), .pin_out_ff(pin_out_ff),
        .pin_oe_ff(pin_oe_ff), .periph_out(periph_out), .periph_oe(periph_oe),
        .periph_in_ff(), .dma_req_ff(dma_req_ff), .ext_irq_ff(ext_irq_ff));
    gsp_ext_dev gsp_ext_dev_i (.clk(clk), .lvl(lvl), .slow(slow), .pins_ff(dev_pins));
    task automatic check(input string what, input logic [63:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr_reg(input logic [31:0] a, dv);
        @(posedge clk);
        addr <= a;
        wdata <= dv;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [31:0] a, e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask
    // bounded wait for an interrupt or dma line to reach a level
    task automatic wait_sig(input int b, input logic lv);
        for (n = 0; n < 40 && sig[b] !== lv; n++) @(negedge clk);
        if (n == 40) begin
            num_errors++;
            $display("BAD sig %0d exp %b seen %b", b, lv, sig[b]);
            test_done;
        end
    endtask
    always @(posedge clk) rd_d <= rd;
    // read data stand for one cycle only, so compare mid-cycle
    always @(negedge clk) begin
        if (rd_d) begin
            exp_w = exp_q.pop_front();
            check("rdata", rdata_ff, exp_w);
        end
    end
    initial begin
        periph_out = {$random(seed), $random(seed)};
        periph_oe = {$random(seed), $random(seed)};
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(negedge clk);
        check("mux", {pin_out_ff[63:32], pin_oe_ff[63:32]},
            {periph_out[63:32], periph_oe[63:32]});
        foreach (regs[i]) rd_reg(regs[i], '0);
        for (k = 0; k < 4; k++) begin
            v = $random(seed);
            wr_reg(regs[k], v);
            rd_reg(regs[k], v);
            wr_reg(regs[k], '0);
        end
        wr_reg(regs[6], '1);
        rd_reg(regs[6], '0);
        $display("registers done");
        gp_in <= {$random(seed), $random(seed)};
        d = $random(seed);
        v = $random(seed);
        wr_reg(`GSP_OFF_DRV_LO, d);
        wr_reg(`GSP_OFF_DATA_LO, v);
        rd_reg(`GSP_OFF_DATA_LO, pin_in[31:0]);
        rd_reg(`GSP_OFF_DATA_HI, pin_in[63:32]);
        @(negedge clk);
        check("oe", pin_oe_ff[31:0], 32'(~d | ~v));
        check("out", pin_out_ff[31:0], v & ~d);
        wr_reg(`GSP_OFF_DRV_LO, '0);
        $display("pins done");
        // odd lines use fall mode with active low set, so the pin still rises
        for (k = 0; k < 6; k++) begin
            slow <= k[0];
            v = k[0] ? (32'h0000_0001 << (24 + k)) | (32'h0000_0009 << (4 * k))
                : 32'h0000_0005 << (4 * k);
            wr_reg(`GSP_OFF_EXT_CFG, v);
            lvl[k] <= 1'b1;
            wait_sig(k, 1'b1);
            wr_reg(`GSP_OFF_EXT_PND, '0);
            rd_reg(`GSP_OFF_EXT_PND, 32'h0000_0001 << k);
            lvl[k] <= 1'b0;
            wr_reg(`GSP_OFF_EXT_PND, 32'h0000_0001 << k);
            rd_reg(`GSP_OFF_EXT_PND, '0);
        end
        $display("edge interrupts done");
        slow <= 1'b0;
        wr_reg(`GSP_OFF_EXT_CFG, 32'h0000_0003);
        lvl[0] <= 1'b1;
        repeat (2) @(posedge clk);
        lvl[0] <= 1'b0;
        repeat (8) begin
            @(negedge clk);
            check("glitch", sig[0], 1'b0);
        end
        @(posedge clk);
        lvl[0] <= 1'b1;
        wait_sig(0, 1'b1);
        rd_reg(`GSP_OFF_EXT_PND, '0);
        lvl[0] <= 1'b0;
        wait_sig(0, 1'b0);
        $display("level interrupt done");
        wr_reg(`GSP_OFF_DMA_CFG, 32'h0000_0007);
        wait_sig(6, 1'b1);
        lvl[6] <= 1'b1;
        wait_sig(6, 1'b0);
        $display("dma done");
        // mid-run reset clears configuration and outputs
        wr_reg(`GSP_OFF_DRV_LO, d);
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        check("rst oe", pin_oe_ff, '0);
        check("rst sig", sig, '0);
        rd_reg(`GSP_OFF_DRV_LO, '0);
        rd_reg(`GSP_OFF_DMA_CFG, '0);
        rd_reg(`GSP_OFF_EXT_CFG, '0);
        $display("reset done");
        test_done;
    end
endmodule // gsp_port_tb
